// ---- core/dso_pkg.sv ----
// package of constants and types for the drive status output logic
package dso_pkg;
    // clock and timing
    localparam int CLK_MHZ = 200;
    localparam int TL_DELAY_MS = 20;
    localparam int TL_DELAY_CYC = TL_DELAY_MS * 1000 * CLK_MHZ;
    localparam int READY_DELAY_MS = 1000;
    localparam int READY_DELAY_CYC = READY_DELAY_MS * 1000 * CLK_MHZ;
    localparam int TICK_MS_CYC = 1000 * CLK_MHZ;
    // measurement widths: frequency in 0.1 Hz, current in 0.1 % of rated
    localparam int FREQ_W = 16;
    localparam int CUR_W = 16;
    localparam int TIME_W = 16;
    localparam int CNT_W = 32;
    // setting limits (0.1 Hz units / 0.1 %)
    localparam logic [FREQ_W-1:0] ARRIVAL_BAND_MAX = 16'h0064;
    localparam logic [FREQ_W-1:0] DETECT_LEVEL_MAX = 16'h04b0;
    localparam logic [FREQ_W-1:0] DETECT_HYST_MAX = 16'h012c;
    localparam logic [CUR_W-1:0] OL_LEVEL_MIN = 16'h0032;
    localparam logic [CUR_W-1:0] OL_LEVEL_MAX = 16'h05dc;
    // release at 90 percent: level * 9 / 10
    localparam int OL_REL_NUM = 9;
    localparam int OL_REL_DEN = 10;
    // output selector codes and factory defaults
    localparam int SEL_W = 5;
    localparam logic [SEL_W-1:0] SEL_RUN = 5'h00;
    localparam logic [SEL_W-1:0] SEL_ARRIVAL = 5'h01;
    localparam logic [SEL_W-1:0] SEL_DETECT = 5'h02;
    localparam logic [SEL_W-1:0] SEL_TORQUE_DLY = 5'h05;
    localparam logic [SEL_W-1:0] SEL_OVERLOAD = 5'h07;
    localparam logic [SEL_W-1:0] SEL_READY = 5'h0a;
    localparam int NUM_OUT = 5;
    // overload mode values
    localparam logic OL_MODE_THERMAL = 1'b0;
    localparam logic OL_MODE_CURRENT = 1'b1;
    // relay polarity values
    localparam logic RELAY_NORMAL = 1'b0;
    localparam logic RELAY_INVERTED = 1'b1;

    typedef logic [SEL_W-1:0] dso_sel_t;
endpackage

// ---- core/dso_qual_timer.sv ----
// qualification timer: output rises after input held for a number of cycles
`timescale 1ns/100ps
`default_nettype none
module dso_qual_timer #(
    parameter int CNT_W = 32
) (
    input wire logic core_clk_in,           // core clock
    input wire logic reset_n_in,            // synchronous reset, active low
    input wire logic enable_in,             // count enable pulse
    input wire logic cond_in,               // condition being qualified
    input wire logic [CNT_W-1:0] limit_in,  // cycles (enables) to hold
    output logic qualified_out              // condition held long enough
);
    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic done;
    } dso_qt_state_t;

    dso_qt_state_t state;
    dso_qt_state_t next_state;

    // count while the condition holds, restart from zero when it drops
    always_comb begin
        next_state = state;
        if (!cond_in) begin
            next_state.count = '0;
            next_state.done = 1'b0;
        end else if (!state.done && enable_in) begin
            if (state.count + CNT_W'(1) >= limit_in) begin
                next_state.done = 1'b1;
            end else begin
                next_state.count = state.count + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign qualified_out = state.done;
endmodule
`default_nettype wire

// ---- core/dso_status_out.sv ----
// status output logic: torque delay, arrival, level detect, overload, relay
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - delayed torque flag after 20 ms limiting
// - outputs default to selectors 0,1,2,7,10
// - relay polarity 0 normal, 1 inverted
// - inverted relay closes once control ready
// - arrival within band around set frequency
// - level flag above detect level
// - level flag releases below level minus hysteresis
// - overload mode: thermal or current source
// - thermal mode uses motor thermal model
// - current mode needs programmed hold time
// - overload level 5 to 150 percent
// - overload releases at 90 percent level
// - overload warning off with second motor
module dso_status_out
    import dso_pkg::*;
#(
    parameter int TL_CYCLES = dso_pkg::TL_DELAY_CYC,        // 20 ms qualification
    parameter int READY_CYCLES = dso_pkg::READY_DELAY_CYC,  // power-on to ready
    parameter int MS_CYCLES = dso_pkg::TICK_MS_CYC          // cycles per ms tick
) (
    input wire logic core_clk_in,                              // 200 MHz clock
    input wire logic reset_n_in,                               // sync reset, low
    input wire logic running_in,                               // drive running
    input wire logic fault_in,                                 // protection active
    input wire logic torque_limit_in,                          // torque limiter
    input wire logic regen_avoid_in,                           // regen avoidance
    input wire logic current_limit_in,                         // current limiter
    input wire logic [dso_pkg::FREQ_W-1:0] out_freq_in,        // 0.1 Hz units
    input wire logic [dso_pkg::FREQ_W-1:0] set_freq_in,        // 0.1 Hz units
    input wire logic [dso_pkg::CUR_W-1:0] out_current_in,      // 0.1 % rated
    input wire logic thermal_warn_in,                          // thermal model level
    input wire logic motor_two_sel_in,                         // second motor
    input wire logic [dso_pkg::FREQ_W-1:0] arrival_band_setting_in,    // band
    input wire logic [dso_pkg::FREQ_W-1:0] detect_level_setting_in,    // level
    input wire logic [dso_pkg::FREQ_W-1:0] detect_hysteresis_setting_in, // hyst
    input wire logic overload_mode_setting_in,                 // 0 thermal
    input wire logic [dso_pkg::CUR_W-1:0] overload_level_setting_in,   // level
    input wire logic [dso_pkg::TIME_W-1:0] overload_time_setting_in,   // ms
    input wire logic relay_polarity_setting_in,                // 1 inverted
    input wire logic sel_load_in,                              // load selectors
    input wire logic [dso_pkg::SEL_W-1:0] sel_data_in,         // selector value
    input wire logic [2:0] sel_index_in,                       // output 0..4
    output logic torque_limit_delayed_flag_out,                // delayed torque
    output logic freq_arrival_flag_out,                        // arrival
    output logic freq_level_flag_one_out,                      // level detect
    output logic overload_warn_flag_out,                       // overload
    output logic ready_out,                                    // drive ready
    output logic status_out_a_out,                             // output a
    output logic status_out_b_out,                             // output b
    output logic status_out_c_out,                             // output c
    output logic status_out_d_out,                             // output d
    output logic relay_e_contact_a_out                         // relay closed
);
    import dso_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        logic [CNT_W-1:0] ms_div;
        logic [CNT_W-1:0] ready_cnt;
        logic ready;
        logic arrival;
        logic level;
        logic ol_raw;
        logic ol_flag;
        logic [NUM_OUT*SEL_W-1:0] sel;
        logic [NUM_OUT-1:0] outs;
        logic relay;
    } dso_state_t;

    dso_state_t state;
    dso_state_t next_state;
    logic tl_flag;
    logic ol_cur_held;
    logic ms_tick;
    logic [CUR_W+3:0] ol_release;

    localparam logic [NUM_OUT*SEL_W-1:0] SEL_DEFAULT =
        {SEL_READY, SEL_OVERLOAD, SEL_DETECT, SEL_ARRIVAL, SEL_RUN};

    // clamp a setting to its maximum
    function automatic logic [FREQ_W-1:0] clamp_max(input logic [FREQ_W-1:0] v,
                                                     input logic [FREQ_W-1:0] mx);
        clamp_max = (v > mx) ? mx : v;
    endfunction

    // map a selector code to the internal flag it names
    function automatic logic pick_flag(input dso_sel_t code, input dso_state_t s,
                                       input logic tl);
        pick_flag = 1'b0;
        case (code)
            SEL_RUN: pick_flag = running_in;
            SEL_ARRIVAL: pick_flag = s.arrival;
            SEL_DETECT: pick_flag = s.level;
            SEL_TORQUE_DLY: pick_flag = tl;
            SEL_OVERLOAD: pick_flag = s.ol_flag;
            SEL_READY: pick_flag = s.ready;
            default: pick_flag = 1'b0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // delayed torque flag: any limiter action must persist for the full window
    dso_qual_timer #(
        .CNT_W(CNT_W)
    ) u_tl_timer (
        .core_clk_in(core_clk_in),
        .reset_n_in(reset_n_in),
        .enable_in(1'b1),
        .cond_in(torque_limit_in | regen_avoid_in | current_limit_in),
        .limit_in(CNT_W'(TL_CYCLES)),
        .qualified_out(tl_flag)
    );

    // current-mode overload hold time, counted in ms ticks
    dso_qual_timer #(
        .CNT_W(CNT_W)
    ) u_ol_timer (
        .core_clk_in(core_clk_in),
        .reset_n_in(reset_n_in),
        .enable_in(ms_tick),
        .cond_in(state.ol_raw),
        .limit_in(CNT_W'(overload_time_setting_in)),
        .qualified_out(ol_cur_held)
    );

    // one-cycle tick as the free-running divider wraps
    assign ms_tick = (state.ms_div == CNT_W'(MS_CYCLES - 1));

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        logic [FREQ_W:0] lo;
        logic [FREQ_W:0] hi;
        logic [FREQ_W-1:0] band;
        logic [FREQ_W-1:0] lvl;
        logic [FREQ_W-1:0] hys;
        logic [CUR_W-1:0] ol_lvl;
        logic sig_e;
        lo = '0;
        hi = '0;
        band = clamp_max(arrival_band_setting_in, ARRIVAL_BAND_MAX);
        lvl = clamp_max(detect_level_setting_in, DETECT_LEVEL_MAX);
        hys = clamp_max(detect_hysteresis_setting_in, DETECT_HYST_MAX);
        ol_lvl = overload_level_setting_in;
        sig_e = 1'b0;
        next_state = state;

        // ms divider runs free; one-cycle tick at wrap
        next_state.ms_div = ms_tick ? '0 : state.ms_div + CNT_W'(1);

        // ready after control voltage settles, dropped while protection active
        if (state.ready_cnt < CNT_W'(READY_CYCLES)) begin
            next_state.ready_cnt = state.ready_cnt + CNT_W'(1);
        end
        next_state.ready = (state.ready_cnt >= CNT_W'(READY_CYCLES)) && !fault_in;

        // arrival window, widened by one bit so edges cannot wrap
        lo = {1'b0, set_freq_in} - {1'b0, band};
        if (band > set_freq_in) begin
            lo = '0;
        end
        hi = {1'b0, set_freq_in} + {1'b0, band};
        next_state.arrival = ({1'b0, out_freq_in} >= lo) &&
                             ({1'b0, out_freq_in} <= hi);

        // level detection with release hysteresis
        if (out_freq_in > lvl) begin
            next_state.level = 1'b1;
        end else if ({1'b0, out_freq_in} + {1'b0, hys} <= {1'b0, lvl}) begin
            next_state.level = 1'b0;
        end

        // overload level limited to the legal range
        if (ol_lvl < OL_LEVEL_MIN) begin
            ol_lvl = OL_LEVEL_MIN;
        end else if (ol_lvl > OL_LEVEL_MAX) begin
            ol_lvl = OL_LEVEL_MAX;
        end

        // release point: 90 percent of the clamped level, so a setting outside
        // the legal range cannot lift the release point above the set point
        ol_release = (CUR_W+4)'(({4'h0, ol_lvl} * (CUR_W+4)'(OL_REL_NUM)) /
                                (CUR_W+4)'(OL_REL_DEN));

        // raw current comparison: before the hold time has run out any dip
        // to the level restarts the qualification; once qualified, only the
        // 90 percent point lets the warning go
        if (out_current_in > ol_lvl) begin
            next_state.ol_raw = 1'b1;
        end else if (!ol_cur_held) begin
            next_state.ol_raw = 1'b0;
        end else if ({4'h0, out_current_in} <= ol_release) begin
            next_state.ol_raw = 1'b0;
        end

        // source select; thermal level comes from the shared motor model
        if (motor_two_sel_in) begin
            next_state.ol_flag = 1'b0;
        end else if (overload_mode_setting_in == OL_MODE_THERMAL) begin
            next_state.ol_flag = thermal_warn_in;
        end else begin
            next_state.ol_flag = ol_cur_held;
        end

        // selector reload; out-of-range index is ignored
        if (sel_load_in && sel_index_in < 3'(NUM_OUT)) begin
            next_state.sel[sel_index_in*SEL_W +: SEL_W] = sel_data_in;
        end

        // route flags to outputs
        for (int i = 0; i < NUM_OUT; i++) begin
            next_state.outs[i] = pick_flag(state.sel[i*SEL_W +: SEL_W], state, tl_flag);
        end

        // relay polarity; inverted relay also waits for control voltage
        sig_e = state.outs[NUM_OUT-1];
        if (relay_polarity_setting_in == RELAY_NORMAL) begin
            next_state.relay = sig_e;
        end else begin
            // contacts stay open until control voltage is up, whatever the signal
            next_state.relay = !sig_e &&
                               state.ready_cnt >= CNT_W'(READY_CYCLES);
        end
    end

    // register the whole state; selectors reset to factory codes
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            state <= '0;
            state.sel <= SEL_DEFAULT;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, all from flip-flops
    assign torque_limit_delayed_flag_out = tl_flag;
    assign freq_arrival_flag_out = state.arrival;
    assign freq_level_flag_one_out = state.level;
    assign overload_warn_flag_out = state.ol_flag;
    assign ready_out = state.ready;
    assign status_out_a_out = state.outs[0];
    assign status_out_b_out = state.outs[1];
    assign status_out_c_out = state.outs[2];
    assign status_out_d_out = state.outs[3];
    assign relay_e_contact_a_out = state.relay;
endmodule
`default_nettype wire

// ---- testbench/dso_status_out_assertions.sv ----
// concurrent checks on the status output logic, bound to its top module
`timescale 1ns/100ps
`default_nettype none
module dso_status_out_assertions #(
    parameter int TL_CYCLES = 20, // torque qualification cycles
    parameter int MS_CYCLES = 4 // cycles per ms tick
) (
    input wire logic core_clk_in, // clock
    input wire logic reset_n_in, // sync reset
    input wire logic torque_limit_in, // limiter
    input wire logic regen_avoid_in, // limiter
    input wire logic current_limit_in, // limiter
    input wire logic [15:0] out_freq_in, // 0.1 hz
    input wire logic [15:0] set_freq_in, // 0.1 hz
    input wire logic [15:0] out_current_in, // 0.1 %
    input wire logic motor_two_sel_in, // second motor
    input wire logic [15:0] arrival_band_setting_in, // band
    input wire logic [15:0] detect_level_setting_in, // level
    input wire logic [15:0] detect_hysteresis_setting_in, // hyst
    input wire logic overload_mode_setting_in, // mode
    input wire logic [15:0] overload_level_setting_in, // level
    input wire logic [15:0] overload_time_setting_in, // ms
    input wire logic torque_limit_delayed_flag_out, // watched
    input wire logic freq_arrival_flag_out, // watched
    input wire logic freq_level_flag_one_out, // watched
    input wire logic overload_warn_flag_out // watched
);
    logic lim, arr_c, lvl_hi, lvl_lo;
    logic [15:0] band, lvl, hy, diff, ovl_lvl;
    int lim_cnt, hi_cnt;
    ////////////////////////////////////////////////////////////////////////////////
    // settings clamped as the design does, so out-of-range values are judged fairly
    assign lim = torque_limit_in | regen_avoid_in | current_limit_in;
    assign band = (arrival_band_setting_in > 16'h0064) ? 16'h0064 : arrival_band_setting_in;
    assign lvl = (detect_level_setting_in > 16'h04b0) ? 16'h04b0 : detect_level_setting_in;
    assign hy = (detect_hysteresis_setting_in > 16'h012c) ? 16'h012c : detect_hysteresis_setting_in;
    assign ovl_lvl = (overload_level_setting_in < 16'h0032) ? 16'h0032 :
        (overload_level_setting_in > 16'h05dc) ? 16'h05dc : overload_level_setting_in;
    assign diff = (out_freq_in > set_freq_in) ? out_freq_in - set_freq_in :
        set_freq_in - out_freq_in;
    assign arr_c = diff <= band;
    assign lvl_hi = out_freq_in > lvl;
    assign lvl_lo = ({1'b0, out_freq_in} + {1'b0, hy}) <= {1'b0, lvl};
    // run lengths of limiter activity and of overcurrent
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            lim_cnt <= 0;
            hi_cnt <= 0;
        end else begin
            lim_cnt <= lim ? lim_cnt + 1 : 0;
            hi_cnt <= (out_current_in > ovl_lvl) ? hi_cnt + 1 : 0;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!reset_n_in);
    sequence s_lim_gone;
        lim ##1 !lim;
    endsequence
    sequence s_second_motor;
        motor_two_sel_in [*3];
    endsequence
    AST_TL_DROP: assert property (s_lim_gone |=> !torque_limit_delayed_flag_out)
        else $error("torque flag held after limiting ended");
    AST_TL_EARLY: assert property (torque_limit_delayed_flag_out |->
        lim_cnt >= TL_CYCLES)
        else $error("torque flag before qualification time");
    AST_TL_LATE: assert property (lim_cnt >= TL_CYCLES |->
        torque_limit_delayed_flag_out)
        else $error("torque flag missing after qualification time");
    AST_ARRIVAL: assert property ($past(reset_n_in) |->
        freq_arrival_flag_out == $past(arr_c))
        else $error("arrival flag disagrees with band");
    AST_LVL_SET: assert property ($past(reset_n_in) && $past(lvl_hi) |->
        freq_level_flag_one_out)
        else $error("level flag not set above level");
    AST_LVL_CLR: assert property ($past(reset_n_in) && $past(lvl_lo) |->
        !freq_level_flag_one_out)
        else $error("level flag not released below hysteresis");
    AST_OVL_M2: assert property (s_second_motor |-> !overload_warn_flag_out)
        else $error("overload warning with second motor");
    AST_OVL_HOLD: assert property ($rose(overload_warn_flag_out) &&
        overload_mode_setting_in |->
        $past(hi_cnt, 2) >= (int'(overload_time_setting_in) - 1) * MS_CYCLES)
        else $error("overload warning before hold time");
endmodule
bind dso_status_out dso_status_out_assertions #(
    .TL_CYCLES(TL_CYCLES), .MS_CYCLES(MS_CYCLES)) u_chk (
    .core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .torque_limit_in(torque_limit_in),
    .regen_avoid_in(regen_avoid_in), .current_limit_in(current_limit_in),
    .out_freq_in(out_freq_in), .set_freq_in(set_freq_in), .out_current_in(out_current_in),
    .motor_two_sel_in(motor_two_sel_in), .arrival_band_setting_in(arrival_band_setting_in),
    .detect_level_setting_in(detect_level_setting_in),
    .detect_hysteresis_setting_in(detect_hysteresis_setting_in),
    .overload_mode_setting_in(overload_mode_setting_in),
    .overload_level_setting_in(overload_level_setting_in),
    .overload_time_setting_in(overload_time_setting_in),
    .torque_limit_delayed_flag_out(torque_limit_delayed_flag_out),
    .freq_arrival_flag_out(freq_arrival_flag_out),
    .freq_level_flag_one_out(freq_level_flag_one_out),
    .overload_warn_flag_out(overload_warn_flag_out));
`default_nettype wire

// ---- testbench/dso_contactor_model.sv ----
// external contactor switched by the relay contacts
`timescale 1ns/100ps
`default_nettype none
module dso_contactor_model #(
    parameter int PULL_CYCLES = 3 // armature pull-in and drop-out delay
) (
    input wire logic core_clk_in, // clock
    input wire logic contact_in, // relay contacts closed
    output logic coil_on_out // contactor energised
);
    logic coil = 1'b0;
    int cnt = 0;
    assign coil_on_out = coil;
    // armature only follows a contact state that has held for a while, so chatter is lost
    always @(posedge core_clk_in) begin
        if (contact_in === coil) begin
            cnt <= 0;
        end else if (cnt == PULL_CYCLES - 1) begin
            coil <= contact_in;
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
// self-checking bench for the drive status output logic
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import dso_pkg::*;
    localparam int TL = 20;
    localparam int RDY = 50;
    localparam int MS = 4;
    logic clk = 1'b0, rst_n = 1'b0, run = 1'b0, fault = 1'b0, tq = 1'b0, rg = 1'b0, cl = 1'b0;
    logic therm = 1'b0, m2 = 1'b0, mode = 1'b0, pol = 1'b0, sload = 1'b0, st;
    logic [15:0] fo = 16'h0000, fs = 16'h0000, cur = 16'h0000, band = 16'h0000, lvl = 16'h0000;
    logic [15:0] hy = 16'h0000, olv = 16'h03e8, ot = 16'h0003;
    logic [4:0] sdata = 5'h00;
    logic [2:0] sidx = 3'h0;
    logic tqf, arr, lvf, ovf, rdy, sa, sb, sc, sd, rel, coil;
    logic [31:0] r;
    int seed = 32'he506;
    int error_cnt = 0;
    int tests_run = 0;
    always #2.5 clk = ~clk;
    dso_status_out #(.TL_CYCLES(TL), .READY_CYCLES(RDY), .MS_CYCLES(MS)) u_dut (
        .core_clk_in(clk), .reset_n_in(rst_n), .running_in(run), .fault_in(fault),
        .torque_limit_in(tq), .regen_avoid_in(rg), .current_limit_in(cl), .out_freq_in(fo),
        .set_freq_in(fs), .out_current_in(cur), .thermal_warn_in(therm), .motor_two_sel_in(m2),
        .arrival_band_setting_in(band), .detect_level_setting_in(lvl),
        .detect_hysteresis_setting_in(hy), .overload_mode_setting_in(mode),
        .overload_level_setting_in(olv), .overload_time_setting_in(ot),
        .relay_polarity_setting_in(pol), .sel_load_in(sload), .sel_data_in(sdata),
        .sel_index_in(sidx), .torque_limit_delayed_flag_out(tqf), .freq_arrival_flag_out(arr),
        .freq_level_flag_one_out(lvf), .overload_warn_flag_out(ovf), .ready_out(rdy),
        .status_out_a_out(sa), .status_out_b_out(sb), .status_out_c_out(sc),
        .status_out_d_out(sd), .relay_e_contact_a_out(rel));
    dso_contactor_model u_load (.core_clk_in(clk), .contact_in(rel), .coil_on_out(coil));
    ////////////////////////////////////////////////////////////////////////////////
    // helpers: inputs move on falling edges, so every check sees settled outputs
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic do_reset(input logic p);
        rst_n = 1'b0;
        pol = p;
        cyc(6);
        rst_n = 1'b1;
    endtask
    task automatic results;
        $display("tests run %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    function automatic logic arr_exp(input logic [15:0] o, input logic [15:0] s,
        input logic [15:0] b);
        logic [15:0] d;
        d = (o > s) ? o - s : s - o;
        return d <= ((b > ARRIVAL_BAND_MAX) ? ARRIVAL_BAND_MAX : b);
    endfunction
    function automatic logic lvl_exp(input logic s, input logic [15:0] o, input logic [15:0] l,
        input logic [15:0] h);
        logic [16:0] lc, hc;
        lc = (l > DETECT_LEVEL_MAX) ? DETECT_LEVEL_MAX : l;
        hc = (h > DETECT_HYST_MAX) ? DETECT_HYST_MAX : h;
        return ({1'b0, o} > lc) ? 1'b1 : (({1'b0, o} + hc <= lc) ? 1'b0 : s);
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    // watchdog: the full sequence needs about 930 cycles
    initial begin
        repeat (6000) @(posedge clk);
        error_cnt++;
        results();
    end
    initial begin
        do_reset(RELAY_NORMAL);
        run = 1'b1;
        fo = 16'h01f4;
        fs = 16'h01f4;
        cyc(3);
        chk("out_a", sa, 1'b1);
        chk("out_b", sb, 1'b1);
        chk("out_c", sc, 1'b1);
        chk("relay", rel, 1'b0);
        cyc(RDY + 5);
        chk("ready", rdy, 1'b1);
        chk("relay", rel, 1'b1);
        chk("contactor", coil, 1'b1);
        fault = 1'b1;
        cyc(4);
        chk("ready", rdy, 1'b0);
        chk("relay", rel, 1'b0);
        pol = RELAY_INVERTED;
        cyc(3);
        chk("relay", rel, 1'b1);
        do_reset(RELAY_INVERTED);
        cyc(10);
        chk("relay", rel, 1'b0);
        cyc(RDY);
        chk("relay", rel, 1'b1);
        fault = 1'b0;
        $display("relay test done");
        // each limiter alone, then an interrupted run that must restart the timer
        for (int k = 0; k < 3; k++) begin
            {cl, rg, tq} = 3'b001 << k;
            cyc(TL - 2);
            chk("torque", tqf, 1'b0);
            cyc(4);
            chk("torque", tqf, 1'b1);
            {cl, rg, tq} = 3'b000;
            cyc(2);
            chk("torque", tqf, 1'b0);
        end
        tq = 1'b1;
        cyc(10);
        tq = 1'b0;
        cyc(1);
        tq = 1'b1;
        sdata = SEL_TORQUE_DLY;
        sload = 1'b1;
        cyc(1);
        sload = 1'b0;
        cyc(14);
        chk("torque", tqf, 1'b0);
        cyc(10);
        chk("out_a", sa, 1'b1);
        tq = 1'b0;
        $display("torque test done");
        // random frequencies, first two exactly on and just past the band edge
        st = 1'b1;
        for (int i = 0; i < 300; i++) begin
            r = $random(seed);
            fs = 16'h0100 + r[9:0];
            band = (i < 2) ? 16'h0064 : 16'($random(seed) & 32'h7f);
            fo = (i < 2) ? fs + 16'h0064 + 16'(i) : fs + 16'($random(seed) % 140);
            lvl = fs + 16'($random(seed) % 60);
            hy = (i % 8 == 0) ? 16'h01ff : 16'($random(seed) & 32'h3f);
            cyc(2);
            st = lvl_exp(st, fo, lvl, hy);
            chk("arrival", arr, arr_exp(fo, fs, band));
            chk("level", lvf, st);
        end
        $display("frequency test done");
        mode = OL_MODE_CURRENT;
        cur = 16'h03e9;
        cyc(5);
        chk("overload", ovf, 1'b0);
        cyc(20);
        chk("overload", ovf, 1'b1);
        chk("out_d", sd, 1'b1);
        cur = 16'h0385;
        cyc(4);
        chk("overload", ovf, 1'b1);
        cur = 16'h0384;
        cyc(3);
        chk("overload", ovf, 1'b0);
        // a dip to the level before the hold time ends restarts the qualification
        cur = 16'h03e9;
        cyc(6);
        cur = 16'h03e0;
        cyc(4);
        cur = 16'h03e9;
        cyc(6);
        chk("overload", ovf, 1'b0);
        olv = 16'h07d0;
        cur = 16'h05dd;
        cyc(25);
        chk("overload", ovf, 1'b1);
        cur = 16'h0000;
        therm = 1'b1;
        cyc(3);
        chk("overload", ovf, 1'b0);
        mode = OL_MODE_THERMAL;
        cyc(3);
        chk("overload", ovf, 1'b1);
        m2 = 1'b1;
        cyc(3);
        chk("overload", ovf, 1'b0);
        $display("overload test done");
        results();
    end
endmodule
`default_nettype wire
